// *** hw/mid_core.sv ***
// execution unit for 14-bit instruction words, driven over AXI4-Lite
// assumes one clock aclk, synchronous reset aresetn, pins asynchronous
`timescale 1ns/10ps
module mid_core (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port pins
	input wire logic [7:0] port_a_pins,
	input wire logic [7:0] port_b_pins,
	output logic [7:0] port_a_latch,
	output logic [7:0] port_b_latch,
	// side effects
	output logic prescaler_clear,
	output logic watchdog_clear_op,
	output logic standby
);
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [13:0] instr_ff;
	logic [7:0] w_ff;
	logic [4:0] status_ff;
	logic [10:0] pc_ff;
	logic [1:0] cyc_ff;
	logic [6:0] faddr_ff;
	logic cfg_psa_ff;
	logic [7:0] file_ff [0:127];
	logic [10:0] stk_ff [0:mid_pkg::STACK_DEPTH-1];
	logic [2:0] sp_ff;
	logic [7:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
	logic presc_ff, wdt_ff, standby_ff;
	logic wr_go, rd_go, exec_go;
	logic [31:0] wmerged;
	logic [31:0] wm_w, wm_s, wm_p;
	logic [13:0] ins;
	logic [7:0] fv;
	mid_pkg::mid_exec_t ex;

	// ==========================================================
	// byte-lane merge for partial writes
	function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// AXI4-Lite handshakes
	// address and data are taken together, so either arrival order works
	assign wr_go = ce && awready_ff && s_axi_awvalid && s_axi_wvalid;
	assign rd_go = ce && arready_ff && s_axi_arvalid;
	assign exec_go = wr_go && (s_axi_awaddr == mid_pkg::A_INSTR);

	// write channel ready pulse and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= mid_pkg::RESP_OKAY;
		end else if (ce) begin
			awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
			wready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr > mid_pkg::A_CONFIG ||
					s_axi_awaddr == mid_pkg::A_INFO) ? mid_pkg::RESP_SLVERR : mid_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// read channel, data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= mid_pkg::RESP_OKAY;
		end else if (ce) begin
			arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
			if (rd_go) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= mid_pkg::RESP_OKAY;
				case (s_axi_araddr)
					mid_pkg::A_INSTR: rdata_ff <= {18'h0, instr_ff};
					mid_pkg::A_WREG: rdata_ff <= {24'h0, w_ff};
					mid_pkg::A_STATUS: rdata_ff <= {27'h0, status_ff};
					mid_pkg::A_PC: rdata_ff <= {21'h0, pc_ff};
					mid_pkg::A_INFO: rdata_ff <= {25'h0, standby_ff, 1'b0, sp_ff, cyc_ff};
					mid_pkg::A_FADDR: rdata_ff <= {25'h0, faddr_ff};
					mid_pkg::A_FDATA: rdata_ff <= {24'h0, file_ff[faddr_ff]};
					mid_pkg::A_CONFIG: rdata_ff <= {31'h0, cfg_psa_ff};
					default: begin
						rdata_ff <= 32'h0000_0000;
						rresp_ff <= mid_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// pin synchronisers; only the second stage feeds the operand path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_s1_ff <= 8'h00;
			pa_s2_ff <= 8'h00;
			pb_s1_ff <= 8'h00;
			pb_s2_ff <= 8'h00;
		end else if (ce) begin
			pa_s1_ff <= port_a_pins;
			pa_s2_ff <= pa_s1_ff;
			pb_s1_ff <= port_b_pins;
			pb_s2_ff <= pb_s1_ff;
		end
	end

	// ==========================================================
	// operand fetch and instruction execution
	always_comb begin
		wmerged = mrg({18'h0, instr_ff}, s_axi_wdata, s_axi_wstrb);
		wm_w = mrg({24'h0, w_ff}, s_axi_wdata, s_axi_wstrb); // software writes keep unstrobed lanes
		wm_s = mrg({27'h0, status_ff}, s_axi_wdata, s_axi_wstrb);
		wm_p = mrg({21'h0, pc_ff}, s_axi_wdata, s_axi_wstrb);
	end
	assign ins = wmerged[13:0];

	// ports read the pins, not the latch, so rewrites see pin levels
	always_comb begin
		if (ins[6:0] == mid_pkg::F_PORTA) begin
			fv = pa_s2_ff;
		end else if (ins[6:0] == mid_pkg::F_PORTB) begin
			fv = pb_s2_ff;
		end else begin
			fv = file_ff[ins[6:0]];
		end
	end

	always_comb begin
		logic [8:0] s9;
		logic [4:0] s5;
		logic skip;
		s9 = 9'h000;
		s5 = 5'h00;
		skip = 1'b0;
		ex = '0;
		ex.pc = pc_ff + 11'h001;
		ex.cyc = mid_pkg::CYC_ONE;
		case (mid_pkg::mid_fmt_t'(ins[13:12]))
			mid_pkg::MID_FMT_BYTE: begin
				ex.wr_w = !ins[7];
				ex.wr_f = ins[7];
				ex.upd_z = 1'b1;
				case (ins[11:8])
					mid_pkg::OP_MISC: begin
						ex.res = w_ff;
						ex.wr_w = 1'b0;
						ex.upd_z = 1'b0;
						if (!ins[7]) begin
							if (ins[7:0] == mid_pkg::W_RETURN || ins[7:0] == mid_pkg::W_RETINT) begin
								ex.pop = 1'b1;
								ex.pc = stk_ff[sp_ff - 3'h1];
								ex.cyc = mid_pkg::CYC_TWO;
							end
							ex.sleep = (ins[7:0] == mid_pkg::W_STANDBY);
							ex.wdt = (ins[7:0] == mid_pkg::W_WDTCLR);
						end
					end
					mid_pkg::OP_CLR: ex.res = 8'h00;
					mid_pkg::OP_ADD, mid_pkg::OP_SUB: begin
						// subtraction adds the complement plus one: carry out means no borrow
						s9 = {1'b0, fv} + ((ins[11:8] == mid_pkg::OP_ADD) ? {1'b0, w_ff} : {1'b0, ~w_ff} + 9'h001);
						s5 = {1'b0, fv[3:0]} + ((ins[11:8] == mid_pkg::OP_ADD) ? {1'b0, w_ff[3:0]} :
							{1'b0, ~w_ff[3:0]} + 5'h01);
						ex.res = s9[7:0];
						ex.c = s9[8];
						ex.dc = s5[4];
						ex.upd_c = 1'b1;
						ex.upd_dc = 1'b1;
					end
					mid_pkg::OP_DEC: ex.res = fv - 8'h01;
					mid_pkg::OP_OR: ex.res = fv | w_ff;
					mid_pkg::OP_AND: ex.res = fv & w_ff;
					mid_pkg::OP_XOR: ex.res = fv ^ w_ff;
					mid_pkg::OP_MOV: ex.res = fv;
					mid_pkg::OP_COM: ex.res = ~fv;
					mid_pkg::OP_INC: ex.res = fv + 8'h01;
					mid_pkg::OP_DECSZ: begin
						ex.res = fv - 8'h01;
						ex.upd_z = 1'b0;
						skip = (ex.res == 8'h00);
					end
					mid_pkg::OP_INCSZ: begin
						ex.res = fv + 8'h01;
						ex.upd_z = 1'b0;
						skip = (ex.res == 8'h00);
					end
					mid_pkg::OP_RRC: begin
						ex.res = {status_ff[mid_pkg::ST_C], fv[7:1]};
						ex.c = fv[0];
						ex.upd_c = 1'b1;
						ex.upd_z = 1'b0;
					end
					mid_pkg::OP_RLC: begin
						ex.res = {fv[6:0], status_ff[mid_pkg::ST_C]};
						ex.c = fv[7];
						ex.upd_c = 1'b1;
						ex.upd_z = 1'b0;
					end
					mid_pkg::OP_SWAP: begin
						ex.res = {fv[3:0], fv[7:4]};
						ex.upd_z = 1'b0;
					end
					default: begin
						ex.wr_w = 1'b0;
						ex.wr_f = 1'b0;
						ex.upd_z = 1'b0;
					end
				endcase
			end
			mid_pkg::MID_FMT_BIT: begin
				ex.res = fv;
				case (ins[11:10])
					mid_pkg::BOP_CLR: begin
						ex.res[ins[9:7]] = 1'b0;
						ex.wr_f = 1'b1;
					end
					mid_pkg::BOP_SET: begin
						ex.res[ins[9:7]] = 1'b1;
						ex.wr_f = 1'b1;
					end
					mid_pkg::BOP_TSC: skip = !fv[ins[9:7]];
					default: skip = fv[ins[9:7]];
				endcase
			end
			mid_pkg::MID_FMT_CTRL: begin
				ex.push = !ins[11];
				ex.pc = ins[10:0];
				ex.cyc = mid_pkg::CYC_TWO;
			end
			default: begin
				ex.wr_w = 1'b1;
				ex.res = ins[7:0];
				casez (ins[11:8])
					4'b00??: ex.res = ins[7:0];
					4'b01??: begin
						ex.pop = 1'b1;
						ex.pc = stk_ff[sp_ff - 3'h1];
						ex.cyc = mid_pkg::CYC_TWO;
					end
					4'b1000: begin
						ex.res = ins[7:0] | w_ff;
						ex.upd_z = 1'b1;
					end
					4'b1001: begin
						ex.res = ins[7:0] & w_ff;
						ex.upd_z = 1'b1;
					end
					4'b110?, 4'b111?: begin
						s9 = {1'b0, ins[7:0]} + (ins[9] ? {1'b0, w_ff} : {1'b0, ~w_ff} + 9'h001);
						s5 = {1'b0, ins[3:0]} + (ins[9] ? {1'b0, w_ff[3:0]} : {1'b0, ~w_ff[3:0]} + 5'h01);
						ex.res = s9[7:0];
						ex.c = s9[8];
						ex.dc = s5[4];
						ex.upd_c = 1'b1;
						ex.upd_dc = 1'b1;
						ex.upd_z = 1'b1;
					end
					default: ex.wr_w = 1'b0;
				endcase
			end
		endcase
		// the skipped word is flushed: pc moves past it and the cycle is a no-op
		if (skip) begin
			ex.pc = pc_ff + 11'h002;
			ex.cyc = mid_pkg::CYC_TWO;
		end
		ex.tmr_clr = ex.wr_f && (ins[6:0] == mid_pkg::F_TIMER0) && cfg_psa_ff;
	end

	// ==========================================================
	// core state: instruction, W, status, pc, cycle count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_ff <= 14'h0000;
			w_ff <= 8'h00;
			status_ff <= mid_pkg::STATUS_RST;
			pc_ff <= mid_pkg::PC_RST;
			cyc_ff <= 2'h0;
		end else if (ce && exec_go) begin
			instr_ff <= ins;
			pc_ff <= ex.pc;
			cyc_ff <= ex.cyc;
			if (ex.wr_w) begin
				w_ff <= ex.res;
			end
			if (ex.upd_c) begin
				status_ff[mid_pkg::ST_C] <= ex.c;
			end
			if (ex.upd_dc) begin
				status_ff[mid_pkg::ST_DC] <= ex.dc;
			end
			if (ex.upd_z) begin
				status_ff[mid_pkg::ST_Z] <= (ex.res == 8'h00);
			end
			// flags read low-true: standby clears powerdown, watchdog clear sets both
			if (ex.sleep || ex.wdt) begin
				status_ff[mid_pkg::ST_TO] <= 1'b1;
				status_ff[mid_pkg::ST_PD] <= ex.wdt;
			end
		end else if (ce && wr_go) begin
			case (s_axi_awaddr)
				mid_pkg::A_WREG: w_ff <= wm_w[7:0];
				mid_pkg::A_STATUS: status_ff <= wm_s[4:0];
				mid_pkg::A_PC: pc_ff <= wm_p[10:0];
				default: begin
				end
			endcase
		end
	end

	// configuration and file pointer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			faddr_ff <= 7'h00;
			cfg_psa_ff <= 1'b0;
		end else if (ce && wr_go) begin
			if (s_axi_awaddr == mid_pkg::A_FADDR && s_axi_wstrb[0]) begin
				faddr_ff <= s_axi_wdata[6:0];
			end
			if (s_axi_awaddr == mid_pkg::A_CONFIG && s_axi_wstrb[0]) begin
				cfg_psa_ff <= s_axi_wdata[0];
			end
		end
	end

	// ==========================================================
	// data file and return stack
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 128; i++) begin
				file_ff[i] <= 8'h00;
			end
		end else if (ce && exec_go && ex.wr_f) begin
			file_ff[ins[6:0]] <= ex.res;
		end else if (ce && wr_go && s_axi_awaddr == mid_pkg::A_FDATA && s_axi_wstrb[0]) begin
			file_ff[faddr_ff] <= s_axi_wdata[7:0];
		end
	end

	// circular stack: overflow silently overwrites the oldest entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_ff <= 3'h0;
			for (int i = 0; i < mid_pkg::STACK_DEPTH; i++) begin
				stk_ff[i] <= 11'h000;
			end
		end else if (ce && exec_go) begin
			if (ex.push) begin
				stk_ff[sp_ff] <= pc_ff + 11'h001;
				sp_ff <= sp_ff + 3'h1;
			end else if (ex.pop) begin
				sp_ff <= sp_ff - 3'h1;
			end
		end
	end

	// ==========================================================
	// side-effect strobes and standby level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_ff <= 1'b0;
			wdt_ff <= 1'b0;
			standby_ff <= 1'b0;
		end else if (ce) begin
			presc_ff <= exec_go && ex.tmr_clr;
			wdt_ff <= exec_go && ex.wdt;
			if (exec_go) begin
				standby_ff <= ex.sleep;
			end
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign port_a_latch = file_ff[mid_pkg::F_PORTA];
	assign port_b_latch = file_ff[mid_pkg::F_PORTB];
	assign prescaler_clear = presc_ff;
	assign watchdog_clear_op = wdt_ff;
	assign standby = standby_ff;
endmodule

// *** hw/mid_pkg.sv ***
// constants, types and the register map of the 14-bit instruction decoder
// assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data
package mid_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] A_INSTR = 8'h00;
	localparam logic [7:0] A_WREG = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_PC = 8'h0C;
	localparam logic [7:0] A_INFO = 8'h10;
	localparam logic [7:0] A_FADDR = 8'h14;
	localparam logic [7:0] A_FDATA = 8'h18;
	localparam logic [7:0] A_CONFIG = 8'h1C;
	// ==========================================================
	// status field positions and reset values
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam logic [4:0] STATUS_RST = 5'h18;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam int STACK_DEPTH = 8;
	// ==========================================================
	// data file addresses with side effects
	localparam logic [6:0] F_TIMER0 = 7'h01;
	localparam logic [6:0] F_PORTA = 7'h05;
	localparam logic [6:0] F_PORTB = 7'h06;
	// ==========================================================
	// byte-oriented operation field
	localparam logic [3:0] OP_MISC = 4'h0;
	localparam logic [3:0] OP_CLR = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_DEC = 4'h3;
	localparam logic [3:0] OP_OR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_MOV = 4'h8;
	localparam logic [3:0] OP_COM = 4'h9;
	localparam logic [3:0] OP_INC = 4'hA;
	localparam logic [3:0] OP_DECSZ = 4'hB;
	localparam logic [3:0] OP_RRC = 4'hC;
	localparam logic [3:0] OP_RLC = 4'hD;
	localparam logic [3:0] OP_SWAP = 4'hE;
	localparam logic [3:0] OP_INCSZ = 4'hF;
	// control words inside the misc group (low byte)
	localparam logic [7:0] W_RETURN = 8'h08;
	localparam logic [7:0] W_RETINT = 8'h09;
	localparam logic [7:0] W_STANDBY = 8'h63;
	localparam logic [7:0] W_WDTCLR = 8'h64;
	// bit-oriented operation field
	localparam logic [1:0] BOP_CLR = 2'h0;
	localparam logic [1:0] BOP_SET = 2'h1;
	localparam logic [1:0] BOP_TSC = 2'h2;
	localparam logic [1:0] BOP_TSS = 2'h3;
	// cycle counts
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// instruction format in bits 13:12
	typedef enum logic [1:0] {
		MID_FMT_BYTE = 2'b00,
		MID_FMT_BIT = 2'b01,
		MID_FMT_CTRL = 2'b10,
		MID_FMT_LIT = 2'b11
	} mid_fmt_t;
	// outcome of one executed instruction
	typedef struct packed {
		logic [7:0] res;
		logic wr_w;
		logic wr_f;
		logic upd_c;
		logic upd_dc;
		logic upd_z;
		logic c;
		logic dc;
		logic [10:0] pc;
		logic [1:0] cyc;
		logic push;
		logic pop;
		logic sleep;
		logic wdt;
		logic tmr_clr;
	} mid_exec_t;
endpackage

// *** tb/mid_core_properties.sv ***
// checker for the decoder's bus handshakes and side-effect ports
// assumes it is bound to mid_core with ce held high
`timescale 1ns/10ps
module mid_core_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// side effects
	input wire logic [7:0] port_b_latch,
	input wire logic prescaler_clear,
	input wire logic watchdog_clear_op,
	input wire logic standby
);
	// =========================================
	// helpers: a taken write, and a whole instruction word
	wire take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	wire ins = take && s_axi_awaddr == mid_pkg::A_INSTR && s_axi_wstrb[1:0] == 2'h3;
	wire [13:0] word = s_axi_wdata[13:0];
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// =========================================
	// handshakes
	AST_WR_RESP: assert property (take |=> s_axi_bvalid)
		else $error("taken write got no response");
	AST_RD_RESP: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
		else $error("taken read got no data");
	AST_READY_PAIR: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
		else $error("write readies apart or during a response");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	// =========================================
	// execution side effects
	AST_WDT: assert property (ins && word == 14'h0064 |-> ##[1:2] watchdog_clear_op)
		else $error("watchdog clear gave no pulse");
	AST_WDT_CAUSE: assert property (watchdog_clear_op |-> $past(ins) || $past(ins, 2))
		else $error("watchdog pulse without an instruction");
	AST_STBY: assert property (ins && word == 14'h0063 |-> ##[1:2] standby)
		else $error("standby not entered");
	AST_STBY_END: assert property (standby && ins && word != 14'h0063 |-> ##[1:2] !standby)
		else $error("standby kept after next instruction");
	AST_PRESC: assert property (prescaler_clear |-> $past(ins) || $past(ins, 2))
		else $error("prescaler clear without an instruction");
	AST_LATCH: assert property (!$stable(port_b_latch) |-> $past(take))
		else $error("port latch moved without a write");
	// =========================================
	// main scenarios reached
	COV_WDT: cover property (watchdog_clear_op);
	COV_STBY: cover property (standby);
	COV_PRESC: cover property (prescaler_clear);
	COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == mid_pkg::RESP_SLVERR);
endmodule
bind mid_core mid_core_chk i_chk (.*);

// *** tb/mid_pin_model.sv ***
// outside drivers on the two ports of the core
// assumes the bench sets the levels; pins follow at once
`timescale 1ns/10ps
module mid_pin_model (
	// levels applied from outside
	input wire logic [7:0] lvl_a,
	input wire logic [7:0] lvl_b,
	// pins seen by the core
	output logic [7:0] port_a_pins,
	output logic [7:0] port_b_pins
);
	// outside drivers beat the latch, so a read-back sees them
	assign port_a_pins = lvl_a;
	assign port_b_pins = lvl_b;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the 14-bit instruction decoder
// assumes mid_core behind AXI4-Lite, pins from mid_pin_model
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
$display("BAD %0t got %0h want %0h", $time, a, e); end end
module testbench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, pclr, wclr, stby;
	logic [7:0] awaddr, araddr, lvl_a, lvl_b, pa, pb, la, lb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp;
	int failures, samples_checked, npclr, nwclr, n0;
	localparam logic [7:0] RW = mid_pkg::A_WREG, RS = mid_pkg::A_STATUS, RP = mid_pkg::A_PC;
	localparam logic [1:0] OK = mid_pkg::RESP_OKAY;
	// operand tables: literal minus W, byte ops on 3Ch with W 0Fh, literal ops
	logic [7:0] ks[3] = '{8'h03, 8'h02, 8'h01};
	logic [7:0] ws[3] = '{8'h01, 8'h00, 8'hFF};
	logic [4:0] ss[3] = '{5'h1B, 5'h1F, 5'h18};
	logic [3:0] bops[6] = '{mid_pkg::OP_ADD, mid_pkg::OP_AND, mid_pkg::OP_OR,
		mid_pkg::OP_XOR, mid_pkg::OP_SWAP, mid_pkg::OP_SUB};
	logic [7:0] bres[6] = '{8'h4B, 8'h0C, 8'h3F, 8'h33, 8'hC3, 8'h2D};
	logic [5:0] lops[4] = '{6'h38, 6'h39, 6'h30, 6'h3E};
	logic [7:0] lks[4] = '{8'hF0, 8'h3C, 8'h77, 8'h01};
	logic [7:0] lres[4] = '{8'hFF, 8'h0C, 8'h77, 8'h10};
	// =========================================
	// design and pin drivers; ce and strobes held full on
	mid_core i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port_a_pins(pa), .port_b_pins(pb), .port_a_latch(la), .port_b_latch(lb),
		.prescaler_clear(pclr), .watchdog_clear_op(wclr), .standby(stby));
	mid_pin_model i_pins (.lvl_a(lvl_a), .lvl_b(lvl_b), .port_a_pins(pa), .port_b_pins(pb));
	// =========================================
	// clock and pulse counters
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (pclr === 1'b1) npclr++;
		if (wclr === 1'b1) nwclr++;
	end
	// =========================================
	// verdict and bus tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hang();
		failures++;
		$display("BAD %0t bus wait ran out", $time);
		summarize();
	endtask
	// master holds each channel until its own ready, then waits for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		// one idle edge keeps bready from being raised again in this time step
		if (n >= 40) begin
			hang();
		end else begin
			`CHK(bresp, er)
			@(posedge aclk);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		// data taken at the edge where rvalid is seen, then one idle edge
		if (n >= 40) begin
			hang();
		end else begin
			v = rdata;
			`CHK(rresp, er)
			@(posedge aclk);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v, OK);
		`CHK(v, e)
	endtask
	task automatic ex(input logic [13:0] w);
		wr(mid_pkg::A_INSTR, {18'h0, w}, OK);
	endtask
	task automatic ldw(input logic [7:0] k);
		ex({6'h30, k});
	endtask
	task automatic setf(input logic [6:0] f, input logic [7:0] v);
		wr(mid_pkg::A_FADDR, {25'h0, f}, OK);
		wr(mid_pkg::A_FDATA, {24'h0, v}, OK);
	endtask
	task automatic chkf(input logic [6:0] f, input logic [7:0] e);
		wr(mid_pkg::A_FADDR, {25'h0, f}, OK);
		rc(mid_pkg::A_FDATA, {24'h0, e});
	endtask
	task automatic ic(input logic [1:0] cyc);
		logic [31:0] v;
		rd(mid_pkg::A_INFO, v, OK);
		`CHK(v[1:0], cyc)
	endtask
	// skip-capable word: counter advance must match the cycle count
	task automatic xp(input logic [13:0] w, input logic [1:0] cyc);
		logic [31:0] p;
		rd(RP, p, OK);
		ex(w);
		rc(RP, {21'h0, p[10:0] + {9'h0, cyc}});
		ic(cyc);
	endtask
	function automatic logic [13:0] bw(logic [3:0] op, logic dst, logic [6:0] f);
		return {2'b00, op, dst, f};
	endfunction
	function automatic logic [13:0] tw(logic [1:0] op, logic [2:0] b, logic [6:0] f);
		return {2'b01, op, b, f};
	endfunction
	// =========================================
	// main sequence
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		lvl_a = 8'hA5;
		lvl_b = 8'h0F;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(RW, 32'h0);
		rc(RS, 32'h18);
		rc(RP, 32'h0);
		rd(8'h40, d, mid_pkg::RESP_SLVERR);
		wr(mid_pkg::A_INFO, 32'h0, mid_pkg::RESP_SLVERR);
		// literal minus W: positive, zero and wrapped results
		for (int i = 0; i < 3; i++) begin
			ldw(8'h02);
			ex({6'h3C, ks[i]});
			rc(RW, {24'h0, ws[i]});
			rc(RS, {27'h0, ss[i]});
		end
		// file minus W to each destination
		setf(7'h20, 8'h03);
		ldw(8'h02);
		ex(bw(mid_pkg::OP_SUB, 1'b1, 7'h20));
		chkf(7'h20, 8'h01);
		rc(RS, 32'h1B);
		ex(bw(mid_pkg::OP_SUB, 1'b0, 7'h20));
		rc(RW, 32'hFF);
		chkf(7'h20, 8'h01);
		rc(RS, 32'h18);
		ldw(8'h01);
		ex(bw(mid_pkg::OP_XOR, 1'b0, 7'h20));
		rc(RW, 32'h0);
		rc(RS, 32'h1C);
		// byte and literal operation fields
		setf(7'h23, 8'h3C);
		foreach (bops[i]) begin
			ldw(8'h0F);
			ex(bw(bops[i], 1'b0, 7'h23));
			rc(RW, {24'h0, bres[i]});
		end
		rc(RS, 32'h19);
		foreach (lops[i]) begin
			ldw(8'h0F);
			ex({lops[i], lks[i]});
			rc(RW, {24'h0, lres[i]});
		end
		rc(RS, 32'h1A);
		// rotates through carry
		setf(7'h21, 8'h81);
		ex(bw(mid_pkg::OP_RLC, 1'b1, 7'h21));
		chkf(7'h21, 8'h02);
		rc(RS, 32'h1B);
		ex(bw(mid_pkg::OP_RRC, 1'b1, 7'h21));
		chkf(7'h21, 8'h81);
		rc(RS, 32'h1A);
		// skips and bit operations
		setf(7'h22, 8'h01);
		xp(bw(mid_pkg::OP_DECSZ, 1'b1, 7'h22), mid_pkg::CYC_TWO);
		xp(bw(mid_pkg::OP_DECSZ, 1'b1, 7'h22), mid_pkg::CYC_ONE);
		chkf(7'h22, 8'hFF);
		xp(bw(mid_pkg::OP_INCSZ, 1'b1, 7'h22), mid_pkg::CYC_TWO);
		rc(RS, 32'h1A);
		setf(7'h22, 8'h10);
		xp(tw(mid_pkg::BOP_TSC, 3'h4, 7'h22), mid_pkg::CYC_ONE);
		xp(tw(mid_pkg::BOP_TSC, 3'h3, 7'h22), mid_pkg::CYC_TWO);
		xp(tw(mid_pkg::BOP_TSS, 3'h4, 7'h22), mid_pkg::CYC_TWO);
		ex(tw(mid_pkg::BOP_SET, 3'h0, 7'h22));
		ex(tw(mid_pkg::BOP_CLR, 3'h4, 7'h22));
		chkf(7'h22, 8'h01);
		// jump, call, return with literal, unlisted word
		ex(14'h2923);
		rc(RP, 32'h123);
		ex(14'h2200);
		rc(RP, 32'h200);
		ic(mid_pkg::CYC_TWO);
		ex(14'h345A);
		rc(RW, 32'h5A);
		rc(RP, 32'h124);
		ic(mid_pkg::CYC_TWO);
		xp(14'h3A55, mid_pkg::CYC_ONE);
		rc(RS, 32'h1A);
		// standby, then watchdog clear wakes it
		ex(14'h0063);
		rc(RS, 32'h12);
		`CHK(stby, 1'b1)
		n0 = nwclr;
		ex(14'h0064);
		rc(RS, 32'h1A);
		`CHK(nwclr, n0 + 1)
		`CHK(stby, 1'b0)
		// read-modify-write of ports takes the pin levels
		setf(mid_pkg::F_PORTB, 8'hFF);
		ex(bw(mid_pkg::OP_MOV, 1'b1, mid_pkg::F_PORTB));
		`CHK(lb, 8'h0F)
		setf(mid_pkg::F_PORTA, 8'hFF);
		ldw(8'hFF);
		ex(bw(mid_pkg::OP_AND, 1'b1, mid_pkg::F_PORTA));
		`CHK(la, 8'hA5)
		// timer count writes clear the prescaler only when it is assigned
		wr(mid_pkg::A_CONFIG, 32'h1, OK);
		n0 = npclr;
		ex(bw(mid_pkg::OP_CLR, 1'b1, mid_pkg::F_TIMER0));
		ex(bw(mid_pkg::OP_MOV, 1'b0, mid_pkg::F_TIMER0));
		wr(mid_pkg::A_CONFIG, 32'h0, OK);
		ex(bw(mid_pkg::OP_CLR, 1'b1, mid_pkg::F_TIMER0));
		ex(bw(mid_pkg::OP_MOV, 1'b0, mid_pkg::F_TIMER0));
		`CHK(npclr, n0 + 1)
		summarize();
	end
endmodule
